// File: core/tcpl_irq.sv
`timescale 1ns/1ps
module tcpl_irq #(
  parameter int WIDTH = 3
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [WIDTH-1:0] ev_set, // event pulses
  input wire logic clr_we, // write-one-to-clear strobe
  input wire logic [WIDTH-1:0] clr_data, // bits to clear
  input wire logic mask_we, // mask write strobe
  input wire logic [WIDTH-1:0] mask_data, // new mask
  output logic [WIDTH-1:0] stat_r, // sticky status
  output logic [WIDTH-1:0] mask_r, // enable mask
  output logic irq_r // level interrupt, high active
);
  logic [WIDTH-1:0] stat_nxt;
  logic [WIDTH-1:0] mask_nxt;
  logic irq_nxt;

  // set wins over clear so a same-cycle event is never lost
  always_comb begin
    stat_nxt = stat_r;
    if (clr_we) begin
      stat_nxt = stat_nxt & ~clr_data;
    end
    stat_nxt = stat_nxt | ev_set;
    mask_nxt = mask_we ? mask_data : mask_r;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end
endmodule

// File: core/tcpl_pkg.sv
package tcpl_pkg;
  // apb geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int EV_W = 3;

  // register byte addresses
  localparam logic [7:0] OFF_USER_CTRL = 8'h00;
  localparam logic [7:0] OFF_VCFG_THREE = 8'h04;
  localparam logic [7:0] OFF_VCFG_SIX = 8'h08;
  localparam logic [7:0] OFF_LOSS_THRESH = 8'h0c;
  localparam logic [7:0] OFF_PIN_STATUS = 8'h10;
  localparam logic [7:0] OFF_INT_STAT = 8'h14;
  localparam logic [7:0] OFF_INT_MASK = 8'h18;

  // user_control_reg fields
  localparam int CTL_SOFT_TX_DISABLE_STATUS = 0;
  localparam int CTL_SOFT_RATE = 1;
  localparam int CTL_INT_PIN_EN = 4;
  // vendor_config_three fields
  localparam int VC3_GEN_MODE = 0;
  localparam int VC3_GEN_LEVEL = 1;
  localparam int VC3_GEN_PUSHPULL = 2;
  // vendor_config_six fields
  localparam int VC6_LOSS_POL = 3;
  // pin status fields
  localparam int STS_TX_DISABLE_STATUS = 0;
  localparam int STS_RATE_IN = 1;
  localparam int STS_RX_LOSS = 2;
  localparam int STS_TX_OFF = 3;
  // event bits, shared by int status and mask
  localparam int EV_TX_DISABLE_STATUS = 0;
  localparam int EV_RATE_IN = 1;
  localparam int EV_RX_LOSS = 2;

  // reset values
  localparam logic [7:0] USER_CTRL_RST = 8'h00;
  localparam logic [7:0] VCFG_THREE_RST = 8'h00;
  localparam logic [7:0] VCFG_SIX_RST = 8'h00;
  localparam logic [7:0] LOSS_THRESH_RST = 8'h00;
  localparam logic [2:0] INT_MASK_RST = 3'h0;

  // apb slave states, one-hot
  typedef enum logic [1:0] {
    TCPL_IDLE = 2'b01,
    TCPL_RESP = 2'b10
  } tcpl_apb_type;
endpackage

// File: core/tcpl_sync.sv
`timescale 1ns/1ps
module tcpl_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [WIDTH-1:0] din, // asynchronous pin levels
  output logic [WIDTH-1:0] dout // synchronised levels
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] dout_nxt;

  // each bit gets its own two-stage chain; stage one feeds only stage two
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      meta_nxt[i] = din[i];
      dout_nxt[i] = meta_r[i];
    end
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        meta_r[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        meta_r[i] <= meta_nxt[i];
        dout[i] <= dout_nxt[i];
      end
    end
  end
endmodule

// File: core/tcpl_top.sv
`timescale 1ns/1ps
// How it works
// - tx held off by pin or soft bit
// - tx disable pin mirrored in status bit
// - interrupt pin enable resets zero, pin analog
// - enabled shared pin drives interrupt open drain
// - rate select output is pin OR soft
// - rate select input mirrored in status bit
// - loss asserted below threshold, cleared above
// - loss output open drain, polarity selectable
// - loss status reports sensed line level
// - rate select mode drives open drain only
// - general output follows level and drive bits
module tcpl_top #(
  parameter int LOSS_W = 8
) (
  input wire logic CLK, // system clock, 100 MHz
  input wire logic NRST, // async reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error, unmapped address
  input wire logic TX_DISABLE_PIN, // tx disable pin, high active
  input wire logic RATE_SELECT_IN, // rate select input pin
  input wire logic RX_LOSS_SENSE, // sensed level of loss line
  input wire logic [LOSS_W-1:0] RX_POWER_INPUT, // rx power code
  output logic TX_DISABLED, // transmitter held off
  output logic SUPPLY_MON_SEL, // shared pin routed to monitor
  output logic SHARED_PIN_O, // shared pin drive value
  output logic SHARED_PIN_OE, // shared pin drive enable
  output logic RATE_SELECT_PIN_O, // rate pin drive value
  output logic RATE_SELECT_PIN_OE, // rate pin drive enable
  output logic RX_LOSS_OUT_O, // loss line drive value
  output logic RX_LOSS_OUT_OE, // loss line drive enable
  output logic IRQ // interrupt, high active
);
  tcpl_pkg::tcpl_apb_type st_r, st_nxt;
  logic [7:0] uctl_r, uctl_nxt;
  logic [7:0] vc3_r, vc3_nxt;
  logic [7:0] vc6_r, vc6_nxt;
  logic [LOSS_W-1:0] thr_r, thr_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [31:0] rd_word;
  logic clr_we, mask_we;
  logic [2:0] pins_s;
  logic tx_dis_s, rate_in_s, loss_sense_s;
  logic [2:0] ev_stat, ev_mask, ev_set;
  logic irq_lvl;
  logic loss_r, loss_nxt;
  logic [2:0] prev_r, prev_nxt;
  logic tx_off_nxt, mon_nxt, sh_oe_nxt;
  logic rs_o_nxt, rs_oe_nxt, rl_oe_nxt, rate_lvl, want_lvl;

  // an address is valid only if it hits one of the seven words
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == tcpl_pkg::OFF_USER_CTRL) ||
      (a == tcpl_pkg::OFF_VCFG_THREE) || (a == tcpl_pkg::OFF_VCFG_SIX) ||
      (a == tcpl_pkg::OFF_LOSS_THRESH) || (a == tcpl_pkg::OFF_PIN_STATUS) ||
      (a == tcpl_pkg::OFF_INT_STAT) || (a == tcpl_pkg::OFF_INT_MASK);
  endfunction

  // pin inputs are asynchronous to CLK
  tcpl_sync #(.WIDTH(3)) u_sync (
    .clk(CLK),
    .nrst(NRST),
    .din({RX_LOSS_SENSE, RATE_SELECT_IN, TX_DISABLE_PIN}),
    .dout(pins_s)
  );
  assign tx_dis_s = pins_s[0];
  assign rate_in_s = pins_s[1];
  assign loss_sense_s = pins_s[2];

  // any level change of a pin is an event
  assign ev_set = pins_s ^ prev_r;

  tcpl_irq #(.WIDTH(tcpl_pkg::EV_W)) u_irq (
    .clk(CLK),
    .nrst(NRST),
    .ev_set(ev_set),
    .clr_we(clr_we),
    .clr_data(PWDATA[2:0]),
    .mask_we(mask_we),
    .mask_data(PWDATA[2:0]),
    .stat_r(ev_stat),
    .mask_r(ev_mask),
    .irq_r(irq_lvl)
  );

  // read mux; status bits 0 to 2 come straight from the synchronisers, bit 3 from TX_DISABLED
  always_comb begin
    rd_word = 32'h0;
    case (PADDR)
      tcpl_pkg::OFF_USER_CTRL: rd_word = {24'h0, uctl_r};
      tcpl_pkg::OFF_VCFG_THREE: rd_word = {24'h0, vc3_r};
      tcpl_pkg::OFF_VCFG_SIX: rd_word = {24'h0, vc6_r};
      tcpl_pkg::OFF_LOSS_THRESH: rd_word[LOSS_W-1:0] = thr_r;
      tcpl_pkg::OFF_PIN_STATUS: begin
        rd_word[tcpl_pkg::STS_TX_DISABLE_STATUS] = tx_dis_s;
        rd_word[tcpl_pkg::STS_RATE_IN] = rate_in_s;
        rd_word[tcpl_pkg::STS_RX_LOSS] = loss_sense_s;
        rd_word[tcpl_pkg::STS_TX_OFF] = TX_DISABLED;
      end
      tcpl_pkg::OFF_INT_STAT: rd_word = {29'h0, ev_stat};
      tcpl_pkg::OFF_INT_MASK: rd_word = {29'h0, ev_mask};
      default: rd_word = 32'h0;
    endcase
  end

  // apb slave: one wait state, writes land on the ready edge
  always_comb begin
    st_nxt = st_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = PRDATA;
    uctl_nxt = uctl_r;
    vc3_nxt = vc3_r;
    vc6_nxt = vc6_r;
    thr_nxt = thr_r;
    clr_we = 1'b0;
    mask_we = 1'b0;
    case (st_r)
      tcpl_pkg::TCPL_IDLE: begin
        if (PSEL && PENABLE) begin
          st_nxt = tcpl_pkg::TCPL_RESP;
          pready_nxt = 1'b1;
          pslverr_nxt = !mapped(PADDR);
          prdata_nxt = PWRITE ? 32'h0 : rd_word;
        end
      end
      tcpl_pkg::TCPL_RESP: begin
        st_nxt = tcpl_pkg::TCPL_IDLE;
        if (PSEL && PENABLE && PWRITE) begin
          case (PADDR)
            tcpl_pkg::OFF_USER_CTRL: uctl_nxt = PWDATA[7:0];
            tcpl_pkg::OFF_VCFG_THREE: vc3_nxt = PWDATA[7:0];
            tcpl_pkg::OFF_VCFG_SIX: vc6_nxt = PWDATA[7:0];
            tcpl_pkg::OFF_LOSS_THRESH: thr_nxt = PWDATA[LOSS_W-1:0];
            tcpl_pkg::OFF_INT_STAT: clr_we = 1'b1;
            tcpl_pkg::OFF_INT_MASK: mask_we = 1'b1;
            default: clr_we = 1'b0;
          endcase
        end
      end
      default: st_nxt = tcpl_pkg::TCPL_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= tcpl_pkg::TCPL_IDLE;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
      uctl_r <= tcpl_pkg::USER_CTRL_RST;
      vc3_r <= tcpl_pkg::VCFG_THREE_RST;
      vc6_r <= tcpl_pkg::VCFG_SIX_RST;
      thr_r <= LOSS_W'(tcpl_pkg::LOSS_THRESH_RST);
    end else begin
      st_r <= st_nxt;
      PREADY <= pready_nxt;
      PSLVERR <= pslverr_nxt;
      PRDATA <= prdata_nxt;
      uctl_r <= uctl_nxt;
      vc3_r <= vc3_nxt;
      vc6_r <= vc6_nxt;
      thr_r <= thr_nxt;
    end
  end

  // pin logic; every pin output is registered to keep glitches off the board
  always_comb begin
    prev_nxt = pins_s;
    // equal power and threshold holds the state, a one-code dead band
    loss_nxt = loss_r;
    if (RX_POWER_INPUT < thr_r) begin
      loss_nxt = 1'b1;
    end else if (RX_POWER_INPUT > thr_r) begin
      loss_nxt = 1'b0;
    end
    tx_off_nxt = tx_dis_s | uctl_r[tcpl_pkg::CTL_SOFT_TX_DISABLE_STATUS];
    mon_nxt = !uctl_r[tcpl_pkg::CTL_INT_PIN_EN];
    // interrupt is active low on the pin: pull down while it is raised
    sh_oe_nxt = uctl_r[tcpl_pkg::CTL_INT_PIN_EN] & irq_lvl;
    rate_lvl = rate_in_s | uctl_r[tcpl_pkg::CTL_SOFT_RATE];
    if (vc3_r[tcpl_pkg::VC3_GEN_MODE]) begin
      if (vc3_r[tcpl_pkg::VC3_GEN_PUSHPULL]) begin
        rs_o_nxt = vc3_r[tcpl_pkg::VC3_GEN_LEVEL];
        rs_oe_nxt = 1'b1;
      end else begin
        rs_o_nxt = 1'b0;
        rs_oe_nxt = !vc3_r[tcpl_pkg::VC3_GEN_LEVEL];
      end
    end else begin
      rs_o_nxt = 1'b0;
      rs_oe_nxt = !rate_lvl;
    end
    // polarity bit set means high for normal operation
    want_lvl = loss_r ^ vc6_r[tcpl_pkg::VC6_LOSS_POL];
    rl_oe_nxt = !want_lvl;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prev_r <= 3'h0;
      loss_r <= 1'b0;
      TX_DISABLED <= 1'b0;
      SUPPLY_MON_SEL <= 1'b1;
      SHARED_PIN_O <= 1'b0;
      SHARED_PIN_OE <= 1'b0;
      RATE_SELECT_PIN_O <= 1'b0;
      RATE_SELECT_PIN_OE <= 1'b0;
      RX_LOSS_OUT_O <= 1'b0;
      RX_LOSS_OUT_OE <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      loss_r <= loss_nxt;
      TX_DISABLED <= tx_off_nxt;
      SUPPLY_MON_SEL <= mon_nxt;
      SHARED_PIN_O <= 1'b0;
      SHARED_PIN_OE <= sh_oe_nxt;
      RATE_SELECT_PIN_O <= rs_o_nxt;
      RATE_SELECT_PIN_OE <= rs_oe_nxt;
      RX_LOSS_OUT_O <= 1'b0;
      RX_LOSS_OUT_OE <= rl_oe_nxt;
      IRQ <= irq_lvl;
    end
  end

  property p_tx_off;
    @(posedge CLK) disable iff (!NRST)
    (tx_dis_s || uctl_r[tcpl_pkg::CTL_SOFT_TX_DISABLE_STATUS]) |=> TX_DISABLED;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("transmitter not held off");

  property p_tx_on;
    @(posedge CLK) disable iff (!NRST)
    (!tx_dis_s && !uctl_r[tcpl_pkg::CTL_SOFT_TX_DISABLE_STATUS]) |=> !TX_DISABLED;
  endproperty
  a_tx_on: assert property (p_tx_on)
    else $error("transmitter off without cause");

  property p_pin_sync;
    @(posedge CLK) disable iff (!NRST)
    $rose(TX_DISABLE_PIN) ##1 TX_DISABLE_PIN [*2] |-> tx_dis_s;
  endproperty
  a_pin_sync: assert property (p_pin_sync)
    else $error("tx disable level not seen after two stages");

  property p_mon_mode;
    @(posedge CLK) disable iff (!NRST)
    !uctl_r[tcpl_pkg::CTL_INT_PIN_EN] |=> SUPPLY_MON_SEL && !SHARED_PIN_OE;
  endproperty
  a_mon_mode: assert property (p_mon_mode)
    else $error("shared pin driven in monitor mode");

  property p_int_pin;
    @(posedge CLK) disable iff (!NRST)
    (uctl_r[tcpl_pkg::CTL_INT_PIN_EN] && irq_lvl) |=>
      SHARED_PIN_OE && !SHARED_PIN_O && !SUPPLY_MON_SEL;
  endproperty
  a_int_pin: assert property (p_int_pin)
    else $error("interrupt not pulled low on shared pin");

  property p_rate_or;
    @(posedge CLK) disable iff (!NRST)
    (!vc3_r[tcpl_pkg::VC3_GEN_MODE] && !rate_lvl) |=> RATE_SELECT_PIN_OE;
  endproperty
  a_rate_or: assert property (p_rate_or)
    else $error("rate select not pulled low when both inputs low");

  property p_rate_od;
    @(posedge CLK) disable iff (!NRST)
    !vc3_r[tcpl_pkg::VC3_GEN_MODE] |=>
      !(RATE_SELECT_PIN_OE && RATE_SELECT_PIN_O);
  endproperty
  a_rate_od: assert property (p_rate_od)
    else $error("rate select driven high");

  property p_gen_pp;
    @(posedge CLK) disable iff (!NRST)
    (vc3_r[tcpl_pkg::VC3_GEN_MODE] && vc3_r[tcpl_pkg::VC3_GEN_PUSHPULL]) |=>
      RATE_SELECT_PIN_OE &&
      (RATE_SELECT_PIN_O == $past(vc3_r[tcpl_pkg::VC3_GEN_LEVEL]));
  endproperty
  a_gen_pp: assert property (p_gen_pp)
    else $error("general output push-pull level wrong");

  property p_loss_set;
    @(posedge CLK) disable iff (!NRST)
    (RX_POWER_INPUT < thr_r) |=> loss_r;
  endproperty
  a_loss_set: assert property (p_loss_set)
    else $error("loss not flagged below threshold");

  property p_loss_clr;
    @(posedge CLK) disable iff (!NRST)
    (RX_POWER_INPUT > thr_r) |=> !loss_r;
  endproperty
  a_loss_clr: assert property (p_loss_clr)
    else $error("loss not cleared above threshold");

  property p_loss_pol;
    @(posedge CLK) disable iff (!NRST)
    !loss_r |=> (RX_LOSS_OUT_OE == !$past(vc6_r[tcpl_pkg::VC6_LOSS_POL]));
  endproperty
  a_loss_pol: assert property (p_loss_pol)
    else $error("loss line normal level wrong for polarity");
endmodule

// File: tb/tcpl_board.sv
`timescale 1ns/1ps
// board around the pins: pull-ups on every open-drain line and an outside
// circuit that may pull the loss line low
module tcpl_board (
  input wire logic loss_oe, // device pull-down on the loss line
  input wire logic loss_o, // device drive value on the loss line
  input wire logic ext_low, // outside circuit pulling the loss line low
  input wire logic rate_oe, // device drive enable on the rate pin
  input wire logic rate_o, // device drive value on the rate pin
  input wire logic shared_oe, // device drive enable on the shared pin
  input wire logic shared_o, // device drive value on the shared pin
  output logic loss_line, // resolved loss line level
  output logic rate_line, // resolved rate pin level
  output logic shared_line // resolved shared pin level
);
  // released lines read high through the pull-up, never the last value
  assign loss_line = ext_low ? 1'b0 : (loss_oe ? loss_o : 1'b1);
  assign rate_line = rate_oe ? rate_o : 1'b1;
  assign shared_line = shared_oe ? shared_o : 1'b1;
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, nrst, psel, penable, pwrite, tx_pin, rs_in, ext_low;
  logic [7:0] paddr, power;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, tx_off, mon_sel, sh_o, sh_oe, rs_o, rs_oe;
  logic los_o, los_oe, irq, los_line, rs_line, sh_line;
  int mismatches, cmp_count;

  tcpl_top i_tcpl_top (.CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TX_DISABLE_PIN(tx_pin), .RATE_SELECT_IN(rs_in),
    .RX_LOSS_SENSE(los_line), .RX_POWER_INPUT(power), .TX_DISABLED(tx_off),
    .SUPPLY_MON_SEL(mon_sel), .SHARED_PIN_O(sh_o), .SHARED_PIN_OE(sh_oe),
    .RATE_SELECT_PIN_O(rs_o), .RATE_SELECT_PIN_OE(rs_oe),
    .RX_LOSS_OUT_O(los_o), .RX_LOSS_OUT_OE(los_oe), .IRQ(irq));

  tcpl_board i_tcpl_board (.loss_oe(los_oe), .loss_o(los_o),
    .ext_low(ext_low), .rate_oe(rs_oe), .rate_o(rs_o), .shared_oe(sh_oe),
    .shared_o(sh_o), .loss_line(los_line), .rate_line(rs_line),
    .shared_line(sh_line));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one apb transfer; an idle cycle follows so psel is never set twice
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      mismatches++;
      print_verdict();
    end
    @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(e, 1'b0);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk(e, 1'b0);
  endtask

  // pins pass a two-stage synchroniser, so allow a few edges
  task settle;
    repeat (6) @(posedge clk);
  endtask

  task t_reset;
    logic [31:0] q;
    logic e;
    // the loss line floats high in reset and settles low after it; that
    // change of the sensed line leaves its event bit set
    for (int a = 0; a < 28; a += 4) begin
      rd(8'(a), (8'(a) == tcpl_pkg::OFF_INT_STAT) ? 32'h4 : 32'h0);
    end
    apb(1'b0, 8'h1c, 32'h0, q, e);
    chk(e, 1'b1);
    chk(q, 32'h0);
    chk(mon_sel, 1'b1);
    chk(sh_oe, 1'b0);
  endtask

  task t_tx;
    for (int i = 0; i < 4; i++) begin
      tx_pin <= i[0];
      wr(tcpl_pkg::OFF_USER_CTRL, {31'h0, i[1]});
      settle;
      chk(tx_off, i[0] | i[1]);
      rd(tcpl_pkg::OFF_PIN_STATUS, {28'h0, i[0] | i[1], 2'b00, i[0]});
    end
    tx_pin <= 1'b0;
    wr(tcpl_pkg::OFF_USER_CTRL, 32'h0);
    settle;
    tx_pin <= 1'b1;
    repeat (2) @(posedge clk);
    chk(tx_off, 1'b0);
    settle;
    chk(tx_off, 1'b1);
    tx_pin <= 1'b0;
    settle;
  endtask

  task t_rate;
    for (int i = 0; i < 4; i++) begin
      rs_in <= i[0];
      wr(tcpl_pkg::OFF_USER_CTRL, {30'h0, i[1], 1'b0});
      settle;
      chk(rs_line, i[0] | i[1]);
      chk(rs_o, 1'b0);
      chk(rs_oe, !(i[0] | i[1]));
      rd(tcpl_pkg::OFF_PIN_STATUS, {30'h0, i[0], 1'b0});
    end
    rs_in <= 1'b0;
    wr(tcpl_pkg::OFF_USER_CTRL, 32'h0);
  endtask

  task t_gpo;
    for (int i = 0; i < 4; i++) begin
      wr(tcpl_pkg::OFF_VCFG_THREE, {29'h0, i[1], i[0], 1'b1});
      settle;
      chk(rs_line, i[0]);
      chk(rs_oe, i[1] | !i[0]);
    end
    wr(tcpl_pkg::OFF_VCFG_THREE, 32'h0);
  endtask

  task t_loss;
    wr(tcpl_pkg::OFF_LOSS_THRESH, 32'h40);
    power <= 8'h30;
    settle;
    chk(los_oe, 1'b0);
    chk(los_line, 1'b1);
    rd(tcpl_pkg::OFF_PIN_STATUS, 32'h4);
    power <= 8'h40;
    settle;
    chk(los_oe, 1'b0);
    power <= 8'h50;
    settle;
    chk(los_line, 1'b0);
    chk(los_o, 1'b0);
    wr(tcpl_pkg::OFF_VCFG_SIX, 32'h8);
    settle;
    chk(los_line, 1'b1);
    ext_low <= 1'b1;
    settle;
    chk(los_oe, 1'b0);
    rd(tcpl_pkg::OFF_PIN_STATUS, 32'h0);
    ext_low <= 1'b0;
    power <= 8'h30;
    settle;
    chk(los_line, 1'b0);
    power <= 8'h50;
    wr(tcpl_pkg::OFF_VCFG_SIX, 32'h0);
    settle;
  endtask

  task t_irq;
    wr(tcpl_pkg::OFF_INT_STAT, 32'h7);
    wr(tcpl_pkg::OFF_INT_MASK, 32'h2);
    chk(irq, 1'b0);
    rs_in <= 1'b1;
    settle;
    chk(irq, 1'b1);
    rd(tcpl_pkg::OFF_INT_STAT, 32'h2);
    wr(tcpl_pkg::OFF_USER_CTRL, 32'h10);
    settle;
    chk(mon_sel, 1'b0);
    chk(sh_line, 1'b0);
    chk(sh_o, 1'b0);
    wr(tcpl_pkg::OFF_INT_MASK, 32'h0);
    settle;
    chk(irq, 1'b0);
    chk(sh_line, 1'b1);
    wr(tcpl_pkg::OFF_INT_MASK, 32'h2);
    wr(tcpl_pkg::OFF_INT_STAT, 32'h2);
    settle;
    chk(irq, 1'b0);
    rd(tcpl_pkg::OFF_INT_STAT, 32'h0);
    wr(tcpl_pkg::OFF_USER_CTRL, 32'h0);
    settle;
    chk(mon_sel, 1'b1);
    chk(sh_oe, 1'b0);
  endtask

  // main sequence
  initial begin
    mismatches = 0;
    cmp_count = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tx_pin = 1'b0;
    rs_in = 1'b0;
    ext_low = 1'b0;
    power = 8'h00;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset;
    t_tx;
    t_rate;
    t_gpo;
    t_loss;
    t_irq;
    print_verdict;
  end
endmodule
